// File: bcwq_pkg.sv
package bcwq_pkg;
  // ------------------------------------------------------------------
  // run-state codes
  // ------------------------------------------------------------------
  localparam logic [1:0] BCWQ_ST_RUN     = 2'h0;
  localparam logic [1:0] BCWQ_ST_GRANTED = 2'h1;
  localparam logic [1:0] BCWQ_ST_IDLE    = 2'h2;
  localparam logic [1:0] BCWQ_ST_STALLED = 2'h3;
  // ------------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------------
  localparam int unsigned BCWQ_MIN_WAIT  = 1;
  localparam logic [7:0]  BCWQ_IDLE_LIM  = 8'h40;
  localparam logic [7:0]  BCWQ_STALL_LIM = 8'h40;
  localparam logic [7:0]  BCWQ_CNT_ONE   = 8'h01;
  localparam logic [7:0]  BCWQ_CNT_ZERO  = 8'h00;

  typedef enum logic [2:0] {
    BCWQ_IDLE  = 3'h1,
    BCWQ_START = 3'h2,
    BCWQ_DATA  = 3'h4
  } bcwq_state_t;
endpackage

// File: bcwq_bus_if.sv
`timescale 1ns/1ps
// bus between probe end and target end, strobes active low, output enables active high
interface bcwq_bus_if;
  logic       transfer_start_strobe_n;
  logic       transfer_start_strobe_oe;
  logic       transfer_in_progress_n;
  logic       transfer_acknowledge_n;
  logic       transfer_error_acknowledge_n;
  logic       burst_inhibit_n;
  logic       bus_grant_n;
  logic       alt_start_strobe_n;
  logic       alt_start_strobe_oe;
  logic       target_reset_n;
  logic [1:0] status_code;

  // wire level of shared start strobe: low if any driver drives low
  logic       start_strobe_wire_n;
  assign start_strobe_wire_n =
    !((transfer_start_strobe_oe && !transfer_start_strobe_n) ||
      (alt_start_strobe_oe && !alt_start_strobe_n));

  modport probe (
    output transfer_start_strobe_n, transfer_start_strobe_oe,
    output transfer_in_progress_n,
    input  transfer_acknowledge_n, transfer_error_acknowledge_n,
    input  burst_inhibit_n, bus_grant_n, target_reset_n,
    input  start_strobe_wire_n,
    output status_code
  );
  modport target (
    input  transfer_start_strobe_n, transfer_start_strobe_oe,
    input  transfer_in_progress_n,
    output transfer_acknowledge_n, transfer_error_acknowledge_n,
    output burst_inhibit_n, bus_grant_n, target_reset_n,
    output alt_start_strobe_n, alt_start_strobe_oe,
    input  start_strobe_wire_n,
    input  status_code
  );
endinterface

// File: bcwq_probe.sv
`timescale 1ns/1ps
// probe end: runs processor cycles, qualifies termination
// one basic cycle, edge by edge:
//   edge 0: request seen, start strobe and in-progress go low
//   edge 1: strobe back high, machine waits for termination
//   edge n: acknowledge or error sampled, done pulses next
// wait mode: acknowledge in the first data clock is dropped,
//   so the far end must hold it past that clock or the
//   cycle stalls until status reports it
// snoop: a strobe seen while the bus is granted away must be
//   answered before the probe starts a cycle of its own
// passive mode: start strobe enable held off and no cycle starts; in-progress and status are still driven
module bcwq_probe (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // bus
  bcwq_bus_if.probe       bus,
  // processor side requests
  input  wire logic       cycle_req,
  input  wire logic       wait_state_mode_setting,
  input  wire logic       passive_mode,
  input  wire logic       run_from_reset,
  input  wire logic       reset_hold_set,
  // results
  output logic            cycle_done,
  output logic            cycle_error,
  output logic            alt_cycle_seen,
  output logic            reset_hold
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // whole module state in one register
  typedef struct packed {
    bcwq_pkg::bcwq_state_t st;
    logic                  ts_n;
    logic                  ts_oe;
    logic                  tip_n;
    logic                  waited;
    logic                  done;
    logic                  err;
    logic                  alt_seen;
    logic                  alt_open;
    logic                  hold;
    logic [7:0]            idle_cnt;
    logic [7:0]            stall_cnt;
    logic [1:0]            status;
  } bcwq_probe_t;

  bcwq_probe_t s_q, s_d;
  // decoded bus conditions
  logic        term;
  logic        in_reset;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    // pulses last one clock
    s_d.done = 1'b0;
    s_d.err  = 1'b0;
    s_d.alt_seen = 1'b0;

    // no cycle starts while either side holds reset
    in_reset = s_q.hold || !bus.target_reset_n;
    // either acknowledge ends the cycle
    term = !bus.transfer_acknowledge_n ||
           !bus.transfer_error_acknowledge_n;

    // --------------------------------------------------------------
    // reset hold from commands
    // --------------------------------------------------------------
    if (run_from_reset) begin
      s_d.hold = 1'b0;
    end else if (reset_hold_set) begin
      s_d.hold = 1'b1;
    end

    // --------------------------------------------------------------
    // cycle machine
    // --------------------------------------------------------------
    case (s_q.st)
      // idle: bus released, wait for an owned request
      bcwq_pkg::BCWQ_IDLE: begin
        s_d.ts_n  = 1'b1;
        s_d.tip_n = 1'b1;
        s_d.ts_oe = 1'b0;
        if (cycle_req && !passive_mode && !in_reset &&
            bus.bus_grant_n == 1'b0 &&
            !s_q.alt_open) begin
          s_d.st    = bcwq_pkg::BCWQ_START;
          s_d.ts_n  = 1'b0;
          s_d.ts_oe = 1'b1;
          s_d.tip_n = 1'b0;
          s_d.waited = 1'b0;
        end
      end

      // start: strobe is one clock only
      bcwq_pkg::BCWQ_START: begin
        s_d.ts_n  = 1'b1;
        s_d.st    = bcwq_pkg::BCWQ_DATA;
        s_d.waited = 1'b0;
      end

      // data: wait for termination
      bcwq_pkg::BCWQ_DATA: begin
        s_d.waited = 1'b1;
        // wait mode: acknowledge ignored in first data clock
        if (term && (!wait_state_mode_setting ||
                     s_q.waited)) begin
          s_d.done = 1'b1;
          s_d.err  = !bus.transfer_error_acknowledge_n;
          // back to back: in-progress stays low
          if (cycle_req && !passive_mode && !in_reset) begin
            s_d.st    = bcwq_pkg::BCWQ_START;
            s_d.ts_n  = 1'b0;
          end else begin
            // no follow-on: release the bus
            s_d.st    = bcwq_pkg::BCWQ_IDLE;
            s_d.tip_n = 1'b1;
            s_d.ts_oe = 1'b0;
          end
        end
      end

      // illegal code: back to idle, bus released
      default: begin
        s_d.st    = bcwq_pkg::BCWQ_IDLE;
        s_d.ts_n  = 1'b1;
        s_d.ts_oe = 1'b0;
        s_d.tip_n = 1'b1;
      end
    endcase

    // --------------------------------------------------------------
    // snoop alternate-master strobes while bus granted away
    // --------------------------------------------------------------
    if (bus.bus_grant_n) begin
      if (!bus.start_strobe_wire_n) begin
        s_d.alt_open = 1'b1;
      end else if (s_q.alt_open && term) begin
        s_d.alt_open = 1'b0;
      end
      if (!bus.start_strobe_wire_n && !in_reset) begin
        s_d.alt_seen = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // activity and stall counters
    // --------------------------------------------------------------
    if (s_d.done || s_d.alt_seen) begin
      s_d.idle_cnt = bcwq_pkg::BCWQ_CNT_ZERO;
    end else if (s_q.idle_cnt != bcwq_pkg::BCWQ_IDLE_LIM) begin
      s_d.idle_cnt = s_q.idle_cnt + bcwq_pkg::BCWQ_CNT_ONE;
    end
    if (s_q.st != bcwq_pkg::BCWQ_DATA || s_d.done) begin
      s_d.stall_cnt = bcwq_pkg::BCWQ_CNT_ZERO;
    end else if (s_q.stall_cnt != bcwq_pkg::BCWQ_STALL_LIM) begin
      s_d.stall_cnt = s_q.stall_cnt + bcwq_pkg::BCWQ_CNT_ONE;
    end

    // --------------------------------------------------------------
    // status code, stall wins over grant over idle
    // --------------------------------------------------------------
    if (s_d.stall_cnt == bcwq_pkg::BCWQ_STALL_LIM) begin
      s_d.status = bcwq_pkg::BCWQ_ST_STALLED;
    end else if (bus.bus_grant_n) begin
      s_d.status = bcwq_pkg::BCWQ_ST_GRANTED;
    end else if (s_d.idle_cnt == bcwq_pkg::BCWQ_IDLE_LIM) begin
      s_d.status = bcwq_pkg::BCWQ_ST_IDLE;
    end else begin
      s_d.status = bcwq_pkg::BCWQ_ST_RUN;
    end

    // --------------------------------------------------------------
    // passive mode forces the start strobe driver off
    // --------------------------------------------------------------
    if (passive_mode) begin
      s_d.ts_oe = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // idle bus, reset hold on
      s_q           <= '0;
      s_q.st        <= bcwq_pkg::BCWQ_IDLE;
      s_q.ts_n      <= 1'b1;
      s_q.tip_n     <= 1'b1;
      s_q.hold      <= 1'b1;
      s_q.status    <= bcwq_pkg::BCWQ_ST_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign bus.transfer_start_strobe_n  = s_q.ts_n;
  assign bus.transfer_start_strobe_oe = s_q.ts_oe;
  assign bus.transfer_in_progress_n   = s_q.tip_n;
  assign bus.status_code              = s_q.status;
  assign cycle_done     = s_q.done;
  assign cycle_error    = s_q.err;
  assign alt_cycle_seen = s_q.alt_seen;
  assign reset_hold     = s_q.hold;
endmodule

// File: bcwq_target.sv
`timescale 1ns/1ps
// target end: answers cycles after a set number of wait states
module bcwq_target (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // bus
  bcwq_bus_if.target      bus,
  // user side
  input  wire logic [3:0] wait_states,
  input  wire logic       give_error,
  input  wire logic       inhibit_burst,
  input  wire logic       grant_away,
  input  wire logic       alt_cycle_req,
  input  wire logic       hold_reset
);
  typedef struct packed {
    logic       busy;
    logic [3:0] cnt;
    logic       ta_n;
    logic       tea_n;
    logic       tbi_n;
    logic       bg_n;
    logic       rst_n;
    logic       ats_n;
    logic       ats_oe;
  } bcwq_target_t;

  bcwq_target_t s_q, s_d;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.bg_n  = grant_away;
    s_d.rst_n = !hold_reset;
    s_d.ats_n = 1'b1;
    s_d.ats_oe = 1'b0;
    if (grant_away && alt_cycle_req && !s_q.busy) begin
      s_d.ats_n  = 1'b0;
      s_d.ats_oe = 1'b1;
    end
    if (!s_q.busy) begin
      if (!bus.start_strobe_wire_n) begin
        s_d.busy = 1'b1;
        s_d.cnt  = wait_states;
        s_d.tbi_n = !inhibit_burst;
        // no wait states: answer sampled on the very next edge
        if (wait_states == 4'h0) begin
          s_d.ta_n  = give_error;
          s_d.tea_n = !give_error;
        end
      end
    end else if (!s_q.ta_n || !s_q.tea_n) begin
      // held one clock; in its random cycles the testbench sets wait_states>=1 with wait mode
      s_d.ta_n  = 1'b1;
      s_d.tea_n = 1'b1;
      s_d.tbi_n = 1'b1;
      s_d.busy  = 1'b0;
    end else if (s_q.cnt == 4'h1) begin
      s_d.cnt   = 4'h0;
      s_d.ta_n  = give_error;
      s_d.tea_n = !give_error;
    end else begin
      s_d.cnt = s_q.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '{busy: 1'b0, cnt: 4'h0, ta_n: 1'b1, tea_n: 1'b1,
               tbi_n: 1'b1, bg_n: 1'b0, rst_n: 1'b0,
               ats_n: 1'b1, ats_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.transfer_acknowledge_n       = s_q.ta_n;
  assign bus.transfer_error_acknowledge_n = s_q.tea_n;
  assign bus.burst_inhibit_n              = s_q.tbi_n;
  assign bus.bus_grant_n                  = s_q.bg_n;
  assign bus.target_reset_n               = s_q.rst_n;
  assign bus.alt_start_strobe_n           = s_q.ats_n;
  assign bus.alt_start_strobe_oe          = s_q.ats_oe;
endmodule

// File: bcwq_properties.sv
`timescale 1ns/1ps
// ------------------------------------
// wire checks between the two ends
// ------------------------------------
module bcwq_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // bus
  input wire logic       transfer_start_strobe_n,
  input wire logic       transfer_start_strobe_oe,
  input wire logic       transfer_in_progress_n,
  input wire logic       transfer_acknowledge_n,
  input wire logic       transfer_error_acknowledge_n,
  input wire logic       bus_grant_n,
  input wire logic [1:0] status_code
);
  // probe strobe, cycle open, termination seen
  logic ps;
  logic transfer_in_progress;
  logic ends;
  assign ps   = transfer_start_strobe_oe && !transfer_start_strobe_n;
  assign transfer_in_progress  = !transfer_in_progress_n;
  assign ends = !transfer_acknowledge_n || !transfer_error_acknowledge_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycle shape
  property p_ts_one; ps |=> !ps; endproperty
  a_ts_one: assert property (p_ts_one) else $error("long strobe");
  property p_tip_ts; ps |-> transfer_in_progress; endproperty
  a_tip_ts: assert property (p_tip_ts) else $error("strobe alone");
  property p_tip_rise; $rose(transfer_in_progress) |-> ps; endproperty
  a_tip_rise: assert property (p_tip_rise) else $error("no start");
  property p_hold; transfer_in_progress && !ends |=> transfer_in_progress; endproperty
  a_hold: assert property (p_hold) else $error("early end");
  // termination and ownership
  property p_end; transfer_in_progress && ends && !ps && !$past(ps) |=> !transfer_in_progress || ps;
  endproperty
  a_end: assert property (p_end) else $error("ack not taken");
  property p_own; ps |-> $past(bus_grant_n) == 1'b0; endproperty
  a_own: assert property (p_own) else $error("start unowned");
  // status codes
  property p_stall;
    status_code == bcwq_pkg::BCWQ_ST_STALLED |-> $past(transfer_in_progress);
  endproperty
  a_stall: assert property (p_stall) else $error("bad stall");
  property p_grant;
    status_code == bcwq_pkg::BCWQ_ST_GRANTED |-> $past(bus_grant_n);
  endproperty
  a_grant: assert property (p_grant) else $error("bad grant");
endmodule

// File: tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
// ------------------------------------
// both ends joined, random cycles
// ------------------------------------
module tb;
  // stimulus and results
  logic        clk_sys = 1'b0, rst_n = 1'b0, req = 1'b0, wmode = 1'b0;
  logic        passive = 1'b0, run_rst = 1'b0, hold_set = 1'b0;
  logic        give_err = 1'b0, inhibit = 1'b0, away = 1'b0;
  logic        alt_req = 1'b0, hold_tgt = 1'b0;
  logic [3:0]  ws = 4'h0;
  logic        done, err, alt_seen, hold, e;
  logic [31:0] seed = 32'h3170;
  int          n_fail = 0, check_count = 0, lat, base, c;
  localparam int LAT0 = 3;  // request edge to done, no wait states
  bcwq_bus_if  bus ();
  always #20 clk_sys = ~clk_sys;
  // the two ends and the wire checker
  bcwq_probe u_bcwq_probe (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .cycle_req(req), .wait_state_mode_setting(wmode),
    .passive_mode(passive), .run_from_reset(run_rst),
    .reset_hold_set(hold_set), .cycle_done(done), .cycle_error(err),
    .alt_cycle_seen(alt_seen), .reset_hold(hold));
  bcwq_target u_bcwq_target (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .wait_states(ws), .give_error(give_err), .inhibit_burst(inhibit),
    .grant_away(away), .alt_cycle_req(alt_req), .hold_reset(hold_tgt));
  bcwq_chk u_bcwq_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .transfer_start_strobe_n(bus.transfer_start_strobe_n),
    .transfer_start_strobe_oe(bus.transfer_start_strobe_oe),
    .transfer_in_progress_n(bus.transfer_in_progress_n),
    .transfer_acknowledge_n(bus.transfer_acknowledge_n),
    .transfer_error_acknowledge_n(bus.transfer_error_acknowledge_n),
    .bus_grant_n(bus.bus_grant_n), .status_code(bus.status_code));
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int exp_lat(input int b, input logic [3:0] w);
    return b + int'(w);
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // count cycles in which a watched output is high
  task automatic watch(input int k, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      tick();
      case (k)
        0: cnt += int'(done === 1'b1);
        1: cnt += int'(alt_seen === 1'b1);
        2: cnt += int'(bus.transfer_in_progress_n === 1'b1);
        default: cnt += int'(bus.transfer_start_strobe_oe === 1'b1);
      endcase
    end
  endtask
  task automatic pulse(input int k);
    if (k == 0) req = 1'b1;
    else if (k == 1) alt_req = 1'b1;
    else if (k == 2) run_rst = 1'b1;
    else hold_set = 1'b1;
    tick();
    {req, alt_req, run_rst, hold_set} = 4'h0;
  endtask
  task automatic run_cycle();
    pulse(0);
    lat = 1;
    while (done !== 1'b1 && lat < 40) begin
      tick();
      lat++;
    end
    e = err;
    if (lat >= 40) begin
      n_fail++;
      close_out();
    end
  endtask
  // main sequence
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(2);
    `CHK("hold", 1'b1, hold)
    req = 1'b1;
    watch(0, 10, c);
    req = 1'b0;
    `CHK("held cycles", 0, c)
    pulse(2);
    `CHK("hold", 1'b0, hold)
    run_cycle();
    base = lat;
    `CHK("first latency", LAT0, base)
    repeat (40) begin
      seed = lfsr(seed);
      wmode = seed[4];
      ws = {2'b00, seed[1:0]} + {3'b000, seed[4]};
      give_err = seed[5];
      inhibit = seed[6];
      tick();
      run_cycle();
      `CHK("latency", exp_lat(LAT0, ws), lat)
      `CHK("error end", give_err, e)
    end
    {wmode, ws} = 5'h10;
    pulse(0);
    watch(0, 90, c);
    `CHK("lost ack", 0, c)
    `CHK("stall", bcwq_pkg::BCWQ_ST_STALLED, bus.status_code)
    {wmode, rst_n} = 2'b00;
    tick(6);
    rst_n = 1'b1;
    tick(2);
    pulse(2);
    req = 1'b1;
    tick(2);
    watch(2, 30, c);
    req = 1'b0;
    `CHK("tip gaps", 0, c)
    `CHK("run", bcwq_pkg::BCWQ_ST_RUN, bus.status_code)
    tick(80);
    `CHK("idle", bcwq_pkg::BCWQ_ST_IDLE, bus.status_code)
    {passive, req} = 2'b11;
    watch(3, 10, c);
    {passive, req} = 2'b00;
    `CHK("passive oe", 0, c)
    away = 1'b1;
    tick(4);
    `CHK("grant", bcwq_pkg::BCWQ_ST_GRANTED, bus.status_code)
    pulse(1);
    watch(1, 10, c);
    `CHK("snoop", 1, c)
    pulse(3);
    pulse(1);
    watch(1, 10, c);
    `CHK("snoop held", 0, c)
    close_out();
  end
endmodule
